// ===== shared/prbs_checker_consts.svh
// Register map, field positions, reset values and sync counts of the checker
`ifndef PRBS_CHECKER_CONSTS_SVH
`define PRBS_CHECKER_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define CTRL_STATUS_IDX     10'h039
`define TOTAL_BYTES_IDX     10'h03A
`define CTRL_STATUS_ADDR    {`CTRL_STATUS_IDX, 2'b00}
`define TOTAL_BYTES_ADDR    {`TOTAL_BYTES_IDX, 2'b00}

// ----------------------------------------------------------------
// Field positions of the control and status register
// ----------------------------------------------------------------
`define FLD_ENABLE          0
`define FLD_CONT_MODE       1
`define FLD_OVERFLOW        2
`define FLD_LOCKED          4
`define FLD_SYNC_LOST       5
`define FLD_ERR_LSB         7
`define FLD_ERR_MSB         14
`define FLD_LOCK_PULSE      7
`define FLD_LOCK_CLEAR      8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTRL_STATUS_RESET   16'h0000
`define TOTAL_BYTES_RESET   16'h0000
`define PRBS_SEED_RESET     7'h7F

// ----------------------------------------------------------------
// Sync acquisition and loss thresholds, in bytes
// ----------------------------------------------------------------
`define LOCK_GOOD_BYTES     3'h4
`define LOSS_BAD_BYTES      3'h4

`endif

// ===== shared/prbs_checker_pkg.sv
// Types shared by the pattern checker modules
package prbs_checker_pkg;

  // Sync state of the pattern checker
  typedef enum logic [1:0]
  {
    st_hunt,
    st_verify,
    st_locked
  } sync_state_t;

  typedef logic [7:0]  err_count_t;
  typedef logic [15:0] byte_count_t;
  typedef logic [6:0]  prbs_state_t;

endpackage

// ===== rtl/prbs_byte_gen.sv
// Next eight bits of the x^7+x^6+1 sequence from a seven-bit state
`timescale 1ns/1ps
module prbs_byte_gen
  import prbs_checker_pkg::*;
(
  // Current generator state, newest bit in bit 0
  input  wire prbs_state_t state_in,
  // Expected byte, first bit in bit 7, and the state after it
  output logic [7:0]       byte_out,
  output prbs_state_t      state_out
);

  // Step the shift register eight times; bits come out MSB first
  always_comb
  begin
    prbs_state_t s;
    logic        nb;
    s        = state_in;
    nb       = 1'b0;
    byte_out = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      nb          = s[6] ^ s[5];
      byte_out[i] = nb;
      s           = {s[5:0], nb};
    end
    state_out = s;
  end

endmodule

// ===== rtl/sat_counter.sv
// Up counter that either saturates or wraps, with a synchronous clear
`timescale 1ns/1ps
module sat_counter
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Control
  input  wire logic             inc,
  input  wire logic             clear,
  input  wire logic             saturate,
  // State
  output logic [WIDTH-1:0]      count,
  output logic                  at_max
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  assign count  = count_r;
  assign at_max = &count_r;

  // A clear still lets a byte of the same cycle count, so none is lost
  always_comb
  begin
    logic [WIDTH-1:0] base;
    base      = clear ? '0 : count_r;
    count_nxt = base;
    if (inc && !(saturate && (&base)))
    begin
      count_nxt = base + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Count register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      count_r <= '0;
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

endmodule

// ===== rtl/prbs_tx_checker.sv
// Transmit-path pattern checker with its APB register slave
//
// Behaviour
// - The checker runs only while the enable bit 0 is set, for use in an external reverse loopback.
// - Control bit 1 set selects continuous counting, clear selects single saturating counting.
// - Errored bytes are counted in eight bits shown at bits 14 to 7, stopping at 0xFF in single mode.
// - Writing a one to bit 7 of the control register makes a lock pulse that freezes the reported counts.
// - Writing a one to bit 8 of the control register makes a combined lock-and-clear pulse.
// - Status bit 5 is set on loss of pattern sync and stays high until the register is read.
// - Status bit 4 shows whether the checker is currently locked to the byte stream.
// - Status bit 2 is set when the total byte counter overflows.
// - All bytes seen by the checker are counted and shown as sixteen bits in a separate register.
// - The total byte count shown is frozen when software writes the lock or lock-and-clear bit.
// - In single mode the total byte count stops at 0xFFFF rather than wrapping.
`timescale 1ns/1ps
`include "prbs_checker_consts.svh"
module prbs_tx_checker
  import prbs_checker_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Looped-back transmit byte stream, same clock domain
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_byte_valid
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RESET_VAL = `CTRL_STATUS_RESET;
  logic        checker_enable_r;
  logic        checker_enable_nxt;
  logic        continuous_count_select_r;
  logic        continuous_count_select_nxt;
  logic        sync_lost_flag_r;
  logic        sync_lost_flag_nxt;
  logic        byte_counter_overflow_r;
  logic        byte_counter_overflow_nxt;
  err_count_t  err_hold_r;
  err_count_t  err_hold_nxt;
  byte_count_t bytes_hold_r;
  byte_count_t bytes_hold_nxt;

  sync_state_t state_r;
  sync_state_t state_nxt;
  prbs_state_t lfsr_r;
  prbs_state_t lfsr_nxt;
  logic [2:0]  run_r;
  logic [2:0]  run_nxt;
  logic        pattern_locked;
  logic        sync_loss_evt;
  logic        err_inc;
  logic        byte_inc;

  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;

  logic        setup_phase;
  logic        access_done;
  logic        hit_ctrl;
  logic        hit_bytes;
  logic        wr_ctrl;
  logic        rd_ctrl;
  logic        lock_pulse;
  logic        lock_clear_pulse;
  logic        freeze;

  logic [7:0]  expect_byte;
  prbs_state_t expect_next;
  logic        byte_match;
  err_count_t  err_live;
  byte_count_t bytes_live;
  logic        bytes_at_max;
  logic        saturate;

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Every access takes one access cycle: pready is raised from the setup
  // cycle, so the completion edge is the first edge with penable high
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_r;
  assign hit_ctrl    = (paddr == `CTRL_STATUS_ADDR);
  assign hit_bytes   = (paddr == `TOTAL_BYTES_ADDR);
  assign wr_ctrl     = access_done && pwrite && hit_ctrl;
  assign rd_ctrl     = access_done && !pwrite && hit_ctrl;

  // Strobes are one cycle wide, taken only at the completion edge
  assign lock_pulse       = wr_ctrl && pstrb[0]
                            && pwdata[`FLD_LOCK_PULSE];
  assign lock_clear_pulse = wr_ctrl && pstrb[1]
                            && pwdata[`FLD_LOCK_CLEAR];
  assign freeze           = lock_pulse || lock_clear_pulse;

  // Answer, registered from the setup cycle
  always_comb
  begin
    prdata_nxt  = 32'h0000_0000;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup_phase)
    begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !(hit_ctrl || hit_bytes);
      if (!pwrite && hit_ctrl)
      begin
        prdata_nxt[`FLD_ENABLE]    = checker_enable_r;
        prdata_nxt[`FLD_CONT_MODE] = continuous_count_select_r;
        prdata_nxt[`FLD_OVERFLOW]  = byte_counter_overflow_r;
        prdata_nxt[`FLD_LOCKED]    = pattern_locked;
        prdata_nxt[`FLD_SYNC_LOST] = sync_lost_flag_r;
        prdata_nxt[`FLD_ERR_MSB:`FLD_ERR_LSB] = err_hold_r;
      end
      else if (!pwrite && hit_bytes)
      begin
        prdata_nxt[15:0] = bytes_hold_r;
      end
    end
  end

  // APB answer registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Control, status flags and held counts
  // ----------------------------------------------------------------
  // The sync-lost flag clears only on a read that showed it set; a loss
  // in the same cycle wins, so no event slips between read and clear
  always_comb
  begin
    checker_enable_nxt          = checker_enable_r;
    continuous_count_select_nxt = continuous_count_select_r;
    sync_lost_flag_nxt          = sync_lost_flag_r;
    byte_counter_overflow_nxt   = byte_counter_overflow_r;
    err_hold_nxt                = err_hold_r;
    bytes_hold_nxt              = bytes_hold_r;
    if (wr_ctrl && pstrb[0])
    begin
      checker_enable_nxt          = pwdata[`FLD_ENABLE];
      continuous_count_select_nxt = pwdata[`FLD_CONT_MODE];
    end
    if (rd_ctrl && prdata_r[`FLD_SYNC_LOST])
      sync_lost_flag_nxt = 1'b0;
    if (sync_loss_evt)
      sync_lost_flag_nxt = 1'b1;
    if (freeze)
    begin
      err_hold_nxt   = err_live;
      bytes_hold_nxt = bytes_live;
    end
    if (lock_clear_pulse)
      byte_counter_overflow_nxt = 1'b0;
    if (byte_inc && bytes_at_max)
      byte_counter_overflow_nxt = 1'b1;
  end

  // Control and status registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      checker_enable_r          <= CTRL_RESET_VAL[`FLD_ENABLE];
      continuous_count_select_r <= CTRL_RESET_VAL[`FLD_CONT_MODE];
      sync_lost_flag_r          <= CTRL_RESET_VAL[`FLD_SYNC_LOST];
      byte_counter_overflow_r   <= CTRL_RESET_VAL[`FLD_OVERFLOW];
      err_hold_r                <= CTRL_RESET_VAL[`FLD_ERR_MSB:`FLD_ERR_LSB];
      bytes_hold_r              <= `TOTAL_BYTES_RESET;
    end
    else
    begin
      checker_enable_r          <= checker_enable_nxt;
      continuous_count_select_r <= continuous_count_select_nxt;
      sync_lost_flag_r          <= sync_lost_flag_nxt;
      byte_counter_overflow_r   <= byte_counter_overflow_nxt;
      err_hold_r                <= err_hold_nxt;
      bytes_hold_r              <= bytes_hold_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pattern sync tracking
  // ----------------------------------------------------------------
  prbs_byte_gen u_gen
  (
    .state_in  (lfsr_r),
    .byte_out  (expect_byte),
    .state_out (expect_next)
  );

  assign byte_match     = (tx_byte == expect_byte);
  assign pattern_locked = (state_r == st_locked);

  // Hunt seeds from the stream itself; once locked the generator free
  // runs so that an errored byte does not corrupt the reference
  always_comb
  begin
    state_nxt     = state_r;
    lfsr_nxt      = lfsr_r;
    run_nxt       = run_r;
    sync_loss_evt = 1'b0;
    err_inc       = 1'b0;
    if (!checker_enable_r)
    begin
      state_nxt = st_hunt;
      run_nxt   = 3'h0;
    end
    else if (tx_byte_valid)
    begin
      case (state_r)
        st_hunt:
        begin
          lfsr_nxt  = tx_byte[6:0];
          run_nxt   = 3'h0;
          state_nxt = st_verify;
        end
        st_verify:
        begin
          lfsr_nxt = tx_byte[6:0];
          if (!byte_match)
            run_nxt = 3'h0;
          else if (run_r == `LOCK_GOOD_BYTES - 3'h1)
          begin
            run_nxt   = 3'h0;
            state_nxt = st_locked;
          end
          else
            run_nxt = run_r + 3'h1;
        end
        st_locked:
        begin
          lfsr_nxt = expect_next;
          if (byte_match)
            run_nxt = 3'h0;
          else
          begin
            err_inc = 1'b1;
            if (run_r == `LOSS_BAD_BYTES - 3'h1)
            begin
              run_nxt       = 3'h0;
              state_nxt     = st_hunt;
              sync_loss_evt = 1'b1;
            end
            else
              run_nxt = run_r + 3'h1;
          end
        end
        default:
        begin
          state_nxt = st_hunt;
          run_nxt   = 3'h0;
        end
      endcase
    end
  end

  // Sync state registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= st_hunt;
      lfsr_r  <= `PRBS_SEED_RESET;
      run_r   <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      lfsr_r  <= lfsr_nxt;
      run_r   <= run_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Live counters
  // ----------------------------------------------------------------
  assign saturate = !continuous_count_select_r;
  assign byte_inc = checker_enable_r && tx_byte_valid;

  // Errored bytes, stop at all ones in single mode
  sat_counter #(.WIDTH(8)) u_err_cnt
  (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .inc      (err_inc),
    .clear    (lock_clear_pulse),
    .saturate (saturate),
    .count    (err_live),
    .at_max   ()
  );

  // All bytes, stop at all ones in single mode
  sat_counter #(.WIDTH(16)) u_byte_cnt
  (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .inc      (byte_inc),
    .clear    (lock_clear_pulse),
    .saturate (saturate),
    .count    (bytes_live),
    .at_max   (bytes_at_max)
  );

endmodule

// ===== test/prbs_tx_checker_monitor.sv
// Port-level assertions for the pattern checker register slave
`timescale 1ns/1ps
`include "prbs_checker_consts.svh"
module prbs_tx_checker_monitor
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // ------
  // Decode
  // ------
  logic mapped;
  logic ctrl_rd;

  // Only two words answer without an error
  assign mapped = paddr == `CTRL_STATUS_ADDR || paddr == `TOTAL_BYTES_ADDR;
  assign ctrl_rd = pready && !pwrite && paddr == `CTRL_STATUS_ADDR;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence setup_s;
    psel && !penable;
  endsequence

  // ----------
  // Properties
  // ----------
  ans_next_a: assert property (setup_s |=> pready)
    else $error("no answer after setup");
  ans_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ans_phase_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_unmap_a: assert property (setup_s ##0 !mapped |=> pslverr)
    else $error("unmapped access accepted");
  err_map_a: assert property (setup_s ##0 mapped |=> !pslverr)
    else $error("mapped access refused");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rd_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  rd_upper_a: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  rsv_zero_a: assert property (ctrl_rd |-> !prdata[15] && !prdata[6]
    && !prdata[3])
    else $error("reserved control bits set");
endmodule

// ===== test/prbs_pattern_source.sv
// Far-end pattern source looping bytes back into the checker
`timescale 1ns/1ps
module prbs_pattern_source
  import prbs_checker_pkg::*;
(
  // Clock and reset
  input  wire logic  clk_sys,
  input  wire logic  resetn,
  // Bench control: send a byte, corrupt it
  input  wire logic  run,
  input  wire logic  inj,
  // Looped-back stream
  output logic [7:0] tx_byte,
  output logic       tx_byte_valid
);
  prbs_state_t st_r;
  prbs_state_t s;
  logic [7:0]  b;

  // Sequence runs on through corrupted bytes, as a real source does
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= 7'h7F;
      tx_byte <= 8'h00;
      tx_byte_valid <= 1'b0;
    end
    else if (run)
    begin
      s = st_r;
      for (int i = 7; i >= 0; i--)
      begin
        b[i] = s[6] ^ s[5];
        s = {s[5:0], b[i]};
      end
      st_r <= s;
      tx_byte <= b ^ {7'h00, inj};
      tx_byte_valid <= 1'b1;
    end
    else
    begin
      // Idle line toggles so a stale byte is never mistaken for data
      tx_byte <= ~tx_byte;
      tx_byte_valid <= 1'b0;
    end
  end
endmodule

// ===== test/tb_prbs_tx_checker.sv
// Self-checking bench for the transmit-path pattern checker
`timescale 1ns/1ps
`include "prbs_checker_consts.svh"
module tb_prbs_tx_checker;
  localparam logic [11:0] CA = `CTRL_STATUS_ADDR;
  localparam logic [11:0] TA = `TOTAL_BYTES_ADDR;
  logic        clk_sys;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  tx_byte;
  logic        tx_byte_valid;
  logic        run;
  logic        inj;
  logic [31:0] rd;
  logic        er;
  int          error_cnt;
  int          comparisons;

  prbs_tx_checker prbs_tx_checker_i (.clk_sys(clk_sys), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid));
  prbs_pattern_source prbs_pattern_source_i (.clk_sys(clk_sys),
    .resetn(resetn), .run(run), .inj(inj), .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid));

  // -------
  // Helpers
  // -------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; only the watchdog ends a wait that never answers
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask

  // Mode 0 clean, 1 all corrupted, 2 every other, 3 bytes 2 and 5
  task automatic send(input int n, input int mode);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      run <= 1'b1;
      inj <= mode == 1 || (mode == 2 && i[0]) ||
             (mode == 3 && (i == 2 || i == 5));
    end
    @(posedge clk_sys);
    run <= 1'b0;
    inj <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  function automatic logic [31:0] cw(int e, int sl, int lk,
                                     int ov, int md, int en);
    return {16'h0000, 1'b0, e[7:0], 1'b0, sl[0], lk[0], 1'b0, ov[0],
            md[0], en[0]};
  endfunction

  task automatic conclude();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------
  // Scenarios
  // ---------
  task automatic t_regs();
    rdc(CA, 32'h0);
    rdc(TA, 32'h0);
    apb(1'b1, TA, 32'hFFFF, 4'hF);
    rdc(TA, 32'h0);
    apb(1'b1, CA, 32'h3, 4'h0);
    rdc(CA, 32'h0);
    apb(1'b0, 12'h100, 32'h0, 4'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, CA, 32'h1, 4'h1);
    rdc(CA, cw(0, 0, 0, 0, 0, 1));
    $display("test regs done");
  endtask

  task automatic t_lock();
    send(20, 0);
    apb(1'b1, CA, 32'h81, 4'h1);
    rdc(TA, 32'h14);
    rdc(CA, cw(0, 0, 1, 0, 0, 1));
    send(5, 0);
    rdc(TA, 32'h14);
    send(10, 3);
    apb(1'b1, CA, 32'h101, 4'h3);
    rdc(CA, cw(2, 0, 1, 0, 0, 1));
    rdc(TA, 32'h23);
    apb(1'b1, CA, 32'h81, 4'h1);
    rdc(TA, 32'h0);
    $display("test lock done");
  endtask

  task automatic t_loss();
    send(4, 1);
    rdc(CA, cw(0, 1, 0, 0, 0, 1));
    rdc(CA, cw(0, 0, 0, 0, 0, 1));
    send(10, 0);
    rdc(CA, cw(0, 0, 1, 0, 0, 1));
    apb(1'b1, CA, 32'h101, 4'h3);
    $display("test loss done");
  endtask

  // Both counters run past their top in single mode
  task automatic t_sat();
    send(66000, 2);
    apb(1'b1, CA, 32'h81, 4'h1);
    rdc(TA, 32'hFFFF);
    rdc(CA, cw(8'hFF, 0, 1, 1, 0, 1));
    apb(1'b1, CA, 32'h103, 4'h3);
    send(520, 2);
    apb(1'b1, CA, 32'h83, 4'h1);
    rdc(CA, cw(4, 0, 1, 0, 1, 1));
    rdc(TA, 32'h208);
    $display("test saturate done");
  endtask

  task automatic t_dis();
    apb(1'b1, CA, 32'h100, 4'h3);
    send(10, 0);
    apb(1'b1, CA, 32'h80, 4'h1);
    rdc(TA, 32'h0);
    rdc(CA, 32'h0);
    $display("test disable done");
  endtask

  // ----
  // Run
  // ----
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial
  begin
    {resetn, psel, penable, pwrite, run, inj} = '0;
    {paddr, pwdata, pstrb} = '0;
    error_cnt = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_lock();
    t_loss();
    t_sat();
    t_dis();
    conclude();
  end

  // Whole run needs about 66700 cycles
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
endmodule

bind prbs_tx_checker prbs_tx_checker_monitor mon_i (.clk_sys(clk_sys),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
